/* src/twcc_top.sv */
/*
 typewriter character control: zero suppression, column split, ribbon colour, cycle delay.
 assumes one character per accepted stream beat and panel impulses as one-cycle pulses.
*/
// Local design decisions: the Avalon-MM slave port and the register offsets.
`default_nettype none
module twcc_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // typewriter track characters
    input  wire logic        trk_valid_i,
    output logic             trk_ready_o,
    input  wire logic [6:0]  trk_char_i,
    // panel impulses
    input  wire logic        supp_on_i,
    input  wire logic        supp_off_i,
    input  wire logic        col_split_i,
    input  wire logic        cc_exit_i,
    input  wire logic        col_entry_i,
    input  wire logic        ribbon_black_i,
    input  wire logic        ribbon_red_i,
    input  wire logic        cycle_delay_in,
    // print mechanism
    output logic             print_valid_o,
    input  wire logic        print_ready_i,
    output logic      [6:0]  print_char_o,
    output logic             ribbon_red_o,
    // panel exits
    output logic             zero_detect_out,
    output logic             zone_bit_out,
    output logic             no_zone_bit_out,
    output logic             col_suspend_o,
    output logic             step_advance_o
);
    localparam int W = twcc_pkg::CHAR_W;

    logic [31:0] pulse;
    logic        f_valid, f_ready;
    logic [W-1:0] f_char;

    // software impulses merge with panel impulses
    logic on_p, off_p, blk_p, red_p, split_p, exit_p, dly_p;
    assign on_p    = supp_on_i      | pulse[twcc_pkg::CTRL_SUPON];
    assign off_p   = supp_off_i     | pulse[twcc_pkg::CTRL_SUPOFF];
    assign blk_p   = ribbon_black_i | pulse[twcc_pkg::CTRL_BLACK];
    assign red_p   = ribbon_red_i   | pulse[twcc_pkg::CTRL_RED];
    assign split_p = col_split_i    | pulse[twcc_pkg::CTRL_SPLIT];
    assign exit_p  = cc_exit_i      | pulse[twcc_pkg::CTRL_CCEXIT];
    assign dly_p   = cycle_delay_in | pulse[twcc_pkg::CTRL_DELAY];

    // the fifo decouples the track from a slow print mechanism
    twcc_fifo #(
        .WIDTH (W),
        .DEPTH (twcc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (trk_valid_i),
        .in_ready_o  (trk_ready_o),
        .in_data_i   (trk_char_i),
        .out_valid_o (f_valid),
        .out_ready_i (f_ready),
        .out_data_o  (f_char)
    );

    function automatic logic is_zero(input logic [W-1:0] c);
        return c == twcc_pkg::CHAR_ZERO;
    endfunction

    twcc_pkg::twcc_state_t st_q, st_d;
    logic        arm_q, arm_d;
    logic        supp_q, supp_d;
    logic        red_q, red_d;
    logic        xbit_q, xbit_d;
    logic        digit_q, digit_d;
    logic        pv_q, pv_d;
    logic [W-1:0] pc_q, pc_d;
    logic        zd_q, zd_d, zx_q, zx_d, nzx_q, nzx_d, susp_q, susp_d, adv_q, adv_d;
    logic        take;
    logic [W-1:0] last_q, last_d;

    // characters move only while running and the printer slot is free or being emptied by print_ready_i this cycle
    assign take    = f_valid & (~pv_q | print_ready_i) & (st_q == twcc_pkg::TWCC_RUN);
    assign f_ready = take;

    always_comb begin
        st_d    = st_q;
        arm_d   = on_p;
        supp_d  = supp_q;
        red_d   = red_q;
        xbit_d  = xbit_q;
        digit_d = digit_q;
        pv_d    = pv_q & ~print_ready_i;
        pc_d    = pc_q;
        last_d  = last_q;
        zd_d    = 1'b0;
        zx_d    = 1'b0;
        nzx_d   = 1'b0;
        susp_d  = 1'b0;
        adv_d   = 1'b0;
        if (arm_q) begin
            supp_d = 1'b1;
        end
        if (blk_p) begin
            red_d = 1'b0;
        end
        if (red_p) begin
            red_d = 1'b1;
        end
        if (take) begin
            last_d = f_char;
            if (supp_d & is_zero(f_char)) begin
                zd_d = 1'b1;
            end else begin
                pv_d = 1'b1;
                pc_d = digit_q ? {{(W-twcc_pkg::DIGIT_W){1'b0}},
                                  f_char[twcc_pkg::DIGIT_W-1:0]} : f_char;
                supp_d = 1'b0;
            end
            digit_d = 1'b0;
        end
        if (off_p) begin
            supp_d = 1'b0;
        end
        unique case (st_q)
            twcc_pkg::TWCC_RUN: begin
                if (split_p & ~col_entry_i) begin
                    xbit_d  = take ? f_char[twcc_pkg::XBIT_POS] : last_q[twcc_pkg::XBIT_POS];
                    digit_d = exit_p;
                    st_d    = twcc_pkg::TWCC_SPLIT;
                end else if (dly_p) begin
                    st_d = twcc_pkg::TWCC_DELAY;
                end
            end
            twcc_pkg::TWCC_SPLIT: begin
                susp_d = 1'b1;
                zx_d   = xbit_q;
                nzx_d  = ~xbit_q;
                st_d   = twcc_pkg::TWCC_RUN;
            end
            twcc_pkg::TWCC_DELAY: begin
                adv_d = 1'b1;
                st_d  = twcc_pkg::TWCC_RUN;
            end
            default: st_d = twcc_pkg::TWCC_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_q    <= twcc_pkg::TWCC_RUN;
            arm_q   <= 1'b0;
            supp_q  <= 1'b0;
            red_q   <= 1'b0;
            xbit_q  <= 1'b0;
            digit_q <= 1'b0;
            pv_q    <= 1'b0;
            pc_q    <= '0;
            last_q  <= '0;
            zd_q    <= 1'b0;
            zx_q    <= 1'b0;
            nzx_q   <= 1'b0;
            susp_q  <= 1'b0;
            adv_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            arm_q   <= arm_d;
            supp_q  <= supp_d;
            red_q   <= red_d;
            xbit_q  <= xbit_d;
            digit_q <= digit_d;
            pv_q    <= pv_d;
            pc_q    <= pc_d;
            last_q  <= last_d;
            zd_q    <= zd_d;
            zx_q    <= zx_d;
            nzx_q   <= nzx_d;
            susp_q  <= susp_d;
            adv_q   <= adv_d;
        end
    end

    assign print_valid_o   = pv_q;
    assign print_char_o    = pc_q;
    assign ribbon_red_o    = red_q;
    assign zero_detect_out = zd_q;
    assign zone_bit_out    = zx_q;
    assign no_zone_bit_out = nzx_q;
    assign col_suspend_o   = susp_q;
    assign step_advance_o  = adv_q;

    twcc_regs u_regs (
        .clk_i         (clk_i),
        .nrst_i        (nrst_i),
        .address_i     (avs_address_i),
        .read_i        (avs_read_i),
        .write_i       (avs_write_i),
        .writedata_i   (avs_writedata_i),
        .readdata_o    (avs_readdata_o),
        .waitrequest_o (avs_waitrequest_o),
        .ctrl_pulse_o  (pulse),
        .status_i      ({26'h0, st_q, red_q, pv_q, supp_q, arm_q}),
        .char_i        ({25'h0, pc_q})
    );

    // a suppressed zero must leave the print slot untouched and pulse the detect exit instead
    zero_blocks_print_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        take && supp_q && !off_p && is_zero(f_char)
        |=> zero_detect_out && !$rose(print_valid_o) && $stable(print_char_o))
        else $error("zero printed");
    supp_off_now_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        off_p |=> !supp_q) else $error("suppression not cleared");
    supp_on_delay_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        on_p && !off_p ##1 !off_p |=> supp_q || zd_q || pv_q) else $error("suppression not armed");
    nonzero_clears_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        take && !is_zero(f_char) && !arm_q |=> !supp_q) else $error("nonzero kept suppression");
    split_exit_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == twcc_pkg::TWCC_SPLIT |=> col_suspend_o && (zone_bit_out ^ no_zone_bit_out)) else $error("split exit");
    ribbon_black_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        blk_p && !red_p |=> !ribbon_red_o) else $error("black not selected");
    ribbon_red_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        red_p |=> ribbon_red_o) else $error("red not selected");
    // control must be back in run in the very cycle the step advance pulses
    delay_resume_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == twcc_pkg::TWCC_RUN && dly_p && !split_p
        |=> st_q == twcc_pkg::TWCC_DELAY ##1 (step_advance_o && st_q == twcc_pkg::TWCC_RUN))
        else $error("delay did not resume");
endmodule
`default_nettype wire

/* src/twcc_pkg.sv */
/*
 package for the typewriter character control block: character codes, register map, fifo sizing.
 assumes a 50 MHz clock and a 32-bit avalon-mm register bus.
*/
`default_nettype none
package twcc_pkg;
    localparam int          CHAR_W       = 7;
    localparam logic [6:0]  CHAR_ZERO    = 7'h00;
    localparam int          XBIT_POS     = 6;
    localparam int          DIGIT_W      = 4;
    localparam int          FIFO_DEPTH   = 32;
    localparam int          ADDR_W       = 4;
    localparam logic [3:0]  REG_CTRL     = 4'h0;
    localparam logic [3:0]  REG_STATUS   = 4'h4;
    localparam logic [3:0]  REG_CHAR     = 4'h8;
    localparam int          CTRL_SUPON   = 0;
    localparam int          CTRL_SUPOFF  = 1;
    localparam int          CTRL_BLACK   = 2;
    localparam int          CTRL_RED     = 3;
    localparam int          CTRL_SPLIT   = 4;
    localparam int          CTRL_CCEXIT  = 5;
    localparam int          CTRL_DELAY   = 6;
    localparam logic [31:0] BAD_ADDR_VAL = 32'hDEADBEEF;
    typedef enum logic [1:0] {
        TWCC_RUN   = 2'b00,
        TWCC_SPLIT = 2'b01,
        TWCC_DELAY = 2'b10
    } twcc_state_t;
endpackage
`default_nettype wire

/* src/twcc_fifo.sv */
/*
 synchronous fifo with valid/ready on both sides.
 assumes one clock and a synchronous active-low reset.
*/
`default_nettype none
module twcc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    // write side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // read side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
    logic             push, pop;

    assign in_ready_o  = (wp_q - rp_q) != (AW+1)'(DEPTH);
    assign out_valid_o = wp_q != rp_q;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem_q[rp_q[AW-1:0]];

    always_comb begin
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop  ? rp_q + 1'b1 : rp_q;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

/* src/twcc_regs.sv */
/*
 avalon-mm slave for control pulses and status of the typewriter character control.
 assumes a master that holds its request until waitrequest is low; answers in the cycle after the request.
*/
`default_nettype none
module twcc_regs (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // avalon-mm slave
    input  wire logic [3:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    // block side
    output logic      [31:0] ctrl_pulse_o,
    input  wire logic [31:0] status_i,
    input  wire logic [31:0] char_i
);
    logic        ack_q, ack_d;
    logic [31:0] rd_q, rd_d;
    logic [31:0] pulse_q, pulse_d;

    // one wait cycle gives registered read data
    assign waitrequest_o = (read_i | write_i) & ~ack_q;
    assign readdata_o    = rd_q;
    assign ctrl_pulse_o  = pulse_q;

    always_comb begin
        ack_d   = (read_i | write_i) & ~ack_q;
        rd_d    = rd_q;
        pulse_d = '0;
        if (read_i & ~ack_q) begin
            unique case (address_i)
                twcc_pkg::REG_CTRL:   rd_d = '0;
                twcc_pkg::REG_STATUS: rd_d = status_i;
                twcc_pkg::REG_CHAR:   rd_d = char_i;
                default:              rd_d = twcc_pkg::BAD_ADDR_VAL;
            endcase
        end
        if (write_i & ack_q & (address_i == twcc_pkg::REG_CTRL)) begin
            pulse_d = writedata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ack_q   <= 1'b0;
            rd_q    <= '0;
            pulse_q <= '0;
        end else begin
            ack_q   <= ack_d;
            rd_q    <= rd_d;
            pulse_q <= pulse_d;
        end
    end
endmodule
`default_nettype wire

/* dv/twcc_printer_model.sv */
/*
 behavioural print mechanism facing the print stream of the character control.
 assumes one clock, synchronous active-low reset; records every accepted character in got.
*/
`default_nettype none
module twcc_printer_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // print stream
    input  wire logic       print_valid_i,
    input  wire logic [6:0] print_char_i,
    output logic            print_ready_o,
    // pacing from the bench
    input  wire logic       stall_i,
    input  wire logic       slow_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] got[$];

    // slow mode accepts every other cycle, like a carriage still moving
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            print_ready_o <= 1'b0;
        end else begin
            if (print_valid_i && print_ready_o) begin
                got.push_back(print_char_i);
            end
            print_ready_o <= !stall_i && (!slow_i || !print_ready_o);
        end
    end
endmodule
`default_nettype wire

/* dv/twcc_top_tb.sv */
/*
 self-checking bench for the typewriter character control top.
 assumes a 50 MHz clock and the printer model on the print stream; panel inputs are bench pulses.
*/
`default_nettype none
module twcc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        trk_valid_i = 1'b0;
    logic        trk_ready_o;
    logic [6:0]  trk_char_i = 7'h00;
    logic [7:0]  pnl = 8'h00;
    logic        print_valid_o;
    logic        print_ready_i;
    logic [6:0]  print_char_o;
    logic        ribbon_red_o;
    logic        zero_detect_out;
    logic        zone_bit_out;
    logic        no_zone_bit_out;
    logic        col_suspend_o;
    logic        step_advance_o;
    logic        stall = 1'b0;
    logic        slow = 1'b0;
    logic [31:0] rd;
    logic        ok;
    int          err_total = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          n_zd = 0;
    int          n_x = 0;
    int          n_nz = 0;
    int          n_sus = 0;
    int          n_stp = 0;
    int          acc;

    always #10 clk_i = ~clk_i;

    // pnl bits: 0 on, 1 off, 2 split, 3 exit, 4 black, 5 red, 6 delay, 7 column entry (never with split)
    twcc_top u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .trk_valid_i(trk_valid_i), .trk_ready_o(trk_ready_o),
        .trk_char_i(trk_char_i), .supp_on_i(pnl[0]), .supp_off_i(pnl[1]), .col_split_i(pnl[2]),
        .cc_exit_i(pnl[3]), .col_entry_i(pnl[7]), .ribbon_black_i(pnl[4]), .ribbon_red_i(pnl[5]),
        .cycle_delay_in(pnl[6]), .print_valid_o(print_valid_o), .print_ready_i(print_ready_i),
        .print_char_o(print_char_o), .ribbon_red_o(ribbon_red_o), .zero_detect_out(zero_detect_out),
        .zone_bit_out(zone_bit_out), .no_zone_bit_out(no_zone_bit_out), .col_suspend_o(col_suspend_o),
        .step_advance_o(step_advance_o));

    twcc_printer_model u_prn (.clk_i(clk_i), .nrst_i(nrst_i), .print_valid_i(print_valid_o),
        .print_char_i(print_char_o), .print_ready_o(print_ready_i), .stall_i(stall), .slow_i(slow));

    task wrap_up;
        if (err_total == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic c, input string m);
        tests_run++;
        if (c !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask

    // pulse counters and the hang limit; the whole run needs a few hundred cycles
    always @(posedge clk_i) begin
        cyc++;
        if (zero_detect_out === 1'b1) n_zd++;
        if (zone_bit_out === 1'b1) n_x++;
        if (no_zone_bit_out === 1'b1) n_nz++;
        if (col_suspend_o === 1'b1) n_sus++;
        if (step_advance_o === 1'b1) n_stp++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up;
        end
    end

    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        // hold everything until waitrequest is seen low at a rising edge; only the global limit ends a hang
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        chk(n == 2, "bus wait states");
    endtask

    task pulse(input logic [7:0] b);
        @(posedge clk_i);
        pnl <= b;
        @(posedge clk_i);
        pnl <= 8'h00;
    endtask

    task send(input logic [6:0] c);
        @(posedge clk_i);
        trk_valid_i <= 1'b1;
        trk_char_i <= c;
        do begin
            @(posedge clk_i);
        end while (trk_ready_o !== 1'b1);
        trk_valid_i <= 1'b0;
    endtask

    task wait_prints(input int n);
        int k;
        k = 0;
        while (u_prn.got.size() < n && k < 500) begin
            @(posedge clk_i);
            k++;
        end
        repeat (3) @(posedge clk_i);
        chk(u_prn.got.size() == n, "print count");
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        bus(1'b0, twcc_pkg::REG_STATUS, 32'h0);
        chk(rd[5:0] === 6'h00, "status after reset");
        bus(1'b0, 4'hC, 32'h0);
        chk(rd === twcc_pkg::BAD_ADDR_VAL, "unmapped read");
        bus(1'b1, 4'hC, 32'hFFFFFFFF);
        bus(1'b0, twcc_pkg::REG_STATUS, 32'h0);
        chk(rd[5:0] === 6'h00, "unmapped write leaked");
        bus(1'b1, twcc_pkg::REG_CTRL, 32'h1 << twcc_pkg::CTRL_SUPON);
        // the on pulse arms first and sets suppression one cycle later
        @(posedge clk_i);
        bus(1'b0, twcc_pkg::REG_STATUS, 32'h0);
        chk(rd[1] === 1'b1, "suppression not set");
        bus(1'b1, twcc_pkg::REG_CTRL, 32'h1 << twcc_pkg::CTRL_SUPOFF);
        bus(1'b0, twcc_pkg::REG_STATUS, 32'h0);
        chk(rd[1] === 1'b0, "suppression not cleared");
        bus(1'b1, twcc_pkg::REG_CTRL, 32'h1 << twcc_pkg::CTRL_RED);
        bus(1'b0, twcc_pkg::REG_STATUS, 32'h0);
        chk(rd[3] === 1'b1 && ribbon_red_o === 1'b1, "red by register");
        bus(1'b1, twcc_pkg::REG_CTRL, 32'h1 << twcc_pkg::CTRL_BLACK);
        bus(1'b0, twcc_pkg::REG_STATUS, 32'h0);
        chk(rd[3] === 1'b0 && ribbon_red_o === 1'b0, "black by register");
        pulse(8'h20);
        repeat (3) @(posedge clk_i);
        chk(ribbon_red_o === 1'b1, "red by panel");
        pulse(8'h10);
        repeat (3) @(posedge clk_i);
        chk(ribbon_red_o === 1'b0, "black by panel");
        // leading zeros against a slow printer
        slow <= 1'b1;
        pulse(8'h01);
        send(7'h00);
        send(7'h00);
        send(7'h05);
        send(7'h00);
        wait_prints(2);
        chk(n_zd == 2, "zero detect count");
        chk(u_prn.got[0] === 7'h05 && u_prn.got[1] === 7'h00, "zero after digit printed");
        bus(1'b0, twcc_pkg::REG_CHAR, 32'h0);
        chk(rd[6:0] === 7'h00, "last char register");
        u_prn.got.delete();
        pulse(8'h01);
        pulse(8'h02);
        send(7'h00);
        wait_prints(1);
        chk(u_prn.got[0] === 7'h00 && n_zd == 2, "off pulse");
        slow <= 1'b0;
        // column split on a zoned and an unzoned character
        send(7'h45);
        wait_prints(2);
        pulse(8'h04);
        repeat (4) @(posedge clk_i);
        chk(n_sus == 1 && n_x == 1 && n_nz == 0, "split with x-bit");
        send(7'h05);
        wait_prints(3);
        pulse(8'h04);
        repeat (4) @(posedge clk_i);
        chk(n_sus == 2 && n_x == 1 && n_nz == 1, "split without x-bit");
        pulse(8'h80);
        repeat (4) @(posedge clk_i);
        chk(n_sus == 2 && n_nz == 1, "entry alone split");
        pulse(8'h40);
        repeat (4) @(posedge clk_i);
        chk(n_stp == 1, "delay step advance");
        // split taken from a column-control exit: the next character prints as its digit
        pulse(8'h0C);
        repeat (4) @(posedge clk_i);
        chk(n_sus == 3 && n_nz == 2, "split from exit");
        send(7'h45);
        wait_prints(4);
        chk(u_prn.got[3] === 7'h05, "exit split digit only");
        // fill the fifo while the printer stalls, then drain it
        stall <= 1'b1;
        u_prn.got.delete();
        acc = 0;
        @(posedge clk_i);
        trk_valid_i <= 1'b1;
        trk_char_i <= 7'h01;
        // every rising edge that sees ready high accepts one character
        repeat (40) begin
            @(posedge clk_i);
            if (trk_ready_o !== 1'b1) break;
            acc++;
            trk_char_i <= 7'(acc + 1);
        end
        trk_valid_i <= 1'b0;
        // the fifo plus the one stalled print slot
        chk(acc == twcc_pkg::FIFO_DEPTH + 1, "fifo depth");
        stall <= 1'b0;
        wait_prints(acc);
        ok = 1'b1;
        for (int i = 0; i < acc; i++) ok &= (u_prn.got[i] === 7'(i + 1));
        chk(ok, "fifo order");
        wrap_up;
    end
endmodule
`default_nettype wire
